// File: core/gmc_bank.sv
// pin mode configuration bank with apb register access
// Notes on behaviour
// [R1] local value driven in local output, and in 111 on link loss
// [R2] x00 functional input, x10 tri-state
// [R3] 001 local output, 011 local input
// [R4] 101 remote value, held on link loss
// [R5] 111 remote value, local bit on loss
// [R6] two-bit modes: 00 func 10 tri 01 out 11 in
// [R7] register-only pins drive with no remote condition
// [R8] pin1/pin2 register field layout
// [R9] pin3 register: 7:4 reserved, value, mode
// [R10] pair register layout, bits 6 and 2 reserved
// [R11] port select redirects pin1..3 registers
// [R12] all configuration registers reset to zero
// [R13] own link lock governs remote fallback
`timescale 1ns/1ps
module gmc_bank (
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [gmc_pkg::ADDR_W-1:0] paddr,
   input wire logic [gmc_pkg::DATA_W-1:0] pwdata,
   output logic [gmc_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [gmc_pkg::NUM_PORTS-1:0] link_lock,
   input wire logic [gmc_pkg::NUM_REMOTE-1:0] gp_pin_remote,
   input wire logic [gmc_pkg::NUM_REMOTE-1:0] second_port_remote,
   input wire logic [gmc_pkg::NUM_REMOTE-1:0] gp_pin_in,
   output logic [gmc_pkg::NUM_REMOTE-1:0] gp_pin_out,
   output logic [gmc_pkg::NUM_REMOTE-1:0] gp_pin_oe,
   input wire logic [gmc_pkg::NUM_REMOTE-1:0] second_port_in,
   output logic [gmc_pkg::NUM_REMOTE-1:0] second_port_out,
   output logic [gmc_pkg::NUM_REMOTE-1:0] second_port_oe,
   input wire logic [gmc_pkg::NUM_REG_ONLY-1:0] reg_only_in,
   output logic [gmc_pkg::NUM_REG_ONLY-1:0] reg_only_out,
   output logic [gmc_pkg::NUM_REG_ONLY-1:0] reg_only_oe
);
   typedef struct packed {
      gmc_pkg::gmc_bus_st_t st;
      logic [gmc_pkg::NUM_PORTS-1:0][gmc_pkg::REG_W-1:0] pin12;
      logic [gmc_pkg::NUM_PORTS-1:0][gmc_pkg::REG_W-1:0] pin3;
      logic [gmc_pkg::REG_W-1:0] pin56;
      logic [gmc_pkg::REG_W-1:0] pin78;
      logic [gmc_pkg::REG_W-1:0] ctrl;
      logic [gmc_pkg::DATA_W-1:0] rdata;
      logic ready;
      logic err;
   } gmc_bank_st_t;

   gmc_bank_st_t st_q;
   gmc_bank_st_t st_d;

   // register index of a byte address, or all ones when misaligned
   function automatic logic [7:0] reg_index(input logic [gmc_pkg::ADDR_W-1:0] a);
      if (a[1:0] != 2'h0) begin
         return 8'hFF;
      end
      return a[9:2];
   endfunction : reg_index

   function automatic logic idx_mapped(input logic [7:0] i);
      return (i == gmc_pkg::IDX_PIN12) || (i == gmc_pkg::IDX_PIN3) ||
             (i == gmc_pkg::IDX_PIN56) || (i == gmc_pkg::IDX_PIN78) ||
             (i == gmc_pkg::IDX_CTRL) || (i == gmc_pkg::IDX_STAT);
   endfunction : idx_mapped

   // mode and value of remote pin k (0..2) from its port's registers
   function automatic logic [3:0] remote_field(input logic [7:0] r12, input logic [7:0] r3,
                                               input int k);
      case (k)
         0: return {r12[gmc_pkg::LOWER_VAL_BIT], r12[gmc_pkg::LOWER_MODE_LSB +: 3]};
         1: return {r12[gmc_pkg::UPPER_VAL_BIT], r12[gmc_pkg::UPPER_MODE_LSB +: 3]};
         default: return {r3[gmc_pkg::LOWER_VAL_BIT], r3[gmc_pkg::LOWER_MODE_LSB +: 3]};
      endcase
   endfunction : remote_field

   // mode and value of register-only pin k (0..3)
   function automatic logic [2:0] reg_only_field(input logic [7:0] r56, input logic [7:0] r78,
                                                 input int k);
      logic [7:0] r;
      r = (k < 2) ? r56 : r78;
      if (k % 2 == 0) begin
         return {r[gmc_pkg::LOWER_VAL_BIT], r[gmc_pkg::LOWER_MODE_LSB +: 2]};
      end
      return {r[gmc_pkg::UPPER_VAL_BIT], r[gmc_pkg::UPPER_MODE_LSB +: 2]};
   endfunction : reg_only_field

   logic port_sel;
   logic [7:0] acc_idx;
   logic acc_go;
   logic [gmc_pkg::NUM_PORTS-1:0][gmc_pkg::NUM_REMOTE-1:0] rem_in_s;
   logic [gmc_pkg::NUM_PORTS-1:0][gmc_pkg::NUM_REMOTE-1:0] rem_remote;
   logic [gmc_pkg::NUM_PORTS-1:0][gmc_pkg::NUM_REMOTE-1:0] rem_pin_in;
   gmc_pkg::gmc_pin_drv_t [gmc_pkg::NUM_PORTS-1:0][gmc_pkg::NUM_REMOTE-1:0] rem_drv;
   gmc_pkg::gmc_pin_drv_t [gmc_pkg::NUM_REG_ONLY-1:0] ro_drv;
   logic [gmc_pkg::NUM_REG_ONLY-1:0] ro_in_s;

   assign port_sel = st_q.ctrl[gmc_pkg::CTRL_PORT_SEL_BIT];
   assign acc_idx = reg_index(paddr);
   assign acc_go = psel && penable && (st_q.st == gmc_pkg::BUS_IDLE);
   assign rem_remote[0] = gp_pin_remote;
   assign rem_remote[1] = second_port_remote;
   assign rem_pin_in[0] = gp_pin_in;
   assign rem_pin_in[1] = second_port_in;

   always_comb begin
      st_d = st_q;
      st_d.ready = 1'b0;
      st_d.err = 1'b0;
      case (st_q.st)
         gmc_pkg::BUS_IDLE: begin
            if (acc_go) begin
               st_d.st = gmc_pkg::BUS_RESP;
               st_d.ready = 1'b1;
               st_d.err = !idx_mapped(acc_idx);
               st_d.rdata = '0;
               case (acc_idx)
                  gmc_pkg::IDX_PIN12: st_d.rdata[7:0] = st_q.pin12[port_sel]; // see [R8] [R11]
                  gmc_pkg::IDX_PIN3: st_d.rdata[7:0] = st_q.pin3[port_sel]; // see [R9] [R11]
                  gmc_pkg::IDX_PIN56: st_d.rdata[7:0] = st_q.pin56; // see [R10]
                  gmc_pkg::IDX_PIN78: st_d.rdata[7:0] = st_q.pin78;
                  gmc_pkg::IDX_CTRL: st_d.rdata[7:0] = st_q.ctrl;
                  gmc_pkg::IDX_STAT: begin
                     st_d.rdata[gmc_pkg::STAT_LOCK0_BIT] = link_lock[0];
                     st_d.rdata[gmc_pkg::STAT_LOCK1_BIT] = link_lock[1];
                     st_d.rdata[gmc_pkg::STAT_IN_LSB +: 3] = rem_in_s[port_sel];
                     st_d.rdata[gmc_pkg::STAT_IN_LSB + 3 +: 4] = ro_in_s;
                  end
                  default: st_d.rdata = '0;
               endcase
               if (pwrite) begin
                  st_d.rdata = '0;
                  case (acc_idx)
                     gmc_pkg::IDX_PIN12: st_d.pin12[port_sel] = pwdata[7:0] & gmc_pkg::MASK_PIN12;
                     gmc_pkg::IDX_PIN3: st_d.pin3[port_sel] = pwdata[7:0] & gmc_pkg::MASK_PIN3;
                     gmc_pkg::IDX_PIN56: st_d.pin56 = pwdata[7:0] & gmc_pkg::MASK_REG_ONLY;
                     gmc_pkg::IDX_PIN78: st_d.pin78 = pwdata[7:0] & gmc_pkg::MASK_REG_ONLY;
                     gmc_pkg::IDX_CTRL: st_d.ctrl = pwdata[7:0] & gmc_pkg::MASK_CTRL;
                     default: st_d.ctrl = st_q.ctrl;
                  endcase
               end
            end
         end
         gmc_pkg::BUS_RESP: begin
            st_d.st = gmc_pkg::BUS_IDLE;
         end
         default: begin
            st_d.st = gmc_pkg::BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_q <= '0; // see [R12]
         st_q.st <= gmc_pkg::BUS_IDLE;
         st_q.pin12 <= {gmc_pkg::NUM_PORTS{gmc_pkg::CFG_RESET}};
         st_q.pin3 <= {gmc_pkg::NUM_PORTS{gmc_pkg::CFG_RESET}};
         st_q.pin56 <= gmc_pkg::CFG_RESET;
         st_q.pin78 <= gmc_pkg::CFG_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign prdata = st_q.rdata;
   assign pready = st_q.ready;
   assign pslverr = st_q.err;

   genvar p;
   genvar k;
   generate
      for (p = 0; p < gmc_pkg::NUM_PORTS; p++) begin : g_port
         for (k = 0; k < gmc_pkg::NUM_REMOTE; k++) begin : g_pin
            logic [3:0] fld;
            assign fld = remote_field(st_q.pin12[p], st_q.pin3[p], k);
            gmc_remote_pin u_pin (
               .clk(clk),
               .srst(srst),
               .mode(fld[2:0]),
               .out_val(fld[3]),
               .remote_val(rem_remote[p][k]),
               .link_lock(link_lock[p]), // see [R13]
               .pin_in(rem_pin_in[p][k]),
               .drv(rem_drv[p][k]),
               .in_sample(rem_in_s[p][k])
            );
         end
      end
      for (k = 0; k < gmc_pkg::NUM_REG_ONLY; k++) begin : g_ro
         logic [2:0] fld;
         assign fld = reg_only_field(st_q.pin56, st_q.pin78, k);
         gmc_reg_pin u_pin (
            .clk(clk),
            .srst(srst),
            .mode(fld[1:0]),
            .out_val(fld[2]),
            .pin_in(reg_only_in[k]),
            .drv(ro_drv[k]),
            .in_sample(ro_in_s[k])
         );
         assign reg_only_out[k] = ro_drv[k].out;
         assign reg_only_oe[k] = ro_drv[k].oe;
      end
      for (k = 0; k < gmc_pkg::NUM_REMOTE; k++) begin : g_out
         assign gp_pin_out[k] = rem_drv[0][k].out;
         assign gp_pin_oe[k] = rem_drv[0][k].oe;
         assign second_port_out[k] = rem_drv[1][k].out;
         assign second_port_oe[k] = rem_drv[1][k].oe;
      end
   endgenerate

   // checks on first-port pin one and register-only pin five
   logic [2:0] m1;
   logic v1;
   logic [1:0] m5;
   logic v5;
   assign m1 = st_q.pin12[0][2:0];
   assign v1 = st_q.pin12[0][3];
   assign m5 = st_q.pin56[1:0];
   assign v5 = st_q.pin56[3];

   sequence s_wr_access(logic [7:0] idx);
      psel && penable && pwrite && (st_q.st == gmc_pkg::BUS_IDLE) && (acc_idx == idx);
   endsequence

   sequence s_answer;
      pready ##1 !pready;
   endsequence

   a_local_out_drive: assert property (@(posedge clk) disable iff (srst) // see [R1]
      gp_pin_oe[0] && !$past(link_lock[0]) |-> ($past(m1) == gmc_pkg::M3_GPIO_OUT &&
      gp_pin_out[0] == $past(v1)) || $past(m1[2]))
      else $error("local value driven outside local output mode");

   a_func_tri_off: assert property (@(posedge clk) disable iff (srst) // see [R2]
      (m1[0] == 1'b0) |=> !gp_pin_oe[0])
      else $error("pin driven in functional or tri-state mode");

   a_gpio_in_off: assert property (@(posedge clk) disable iff (srst) // see [R3]
      (m1 == gmc_pkg::M3_GPIO_IN) |=> !gp_pin_oe[0])
      else $error("pin driven in local input mode");

   a_hold_on_loss: assert property (@(posedge clk) disable iff (srst) // see [R4]
      (m1 == gmc_pkg::M3_REMOTE_HOLD) && link_lock[0] ##1
      (m1 == gmc_pkg::M3_REMOTE_HOLD) && !link_lock[0] && $stable(m1)
      |=> gp_pin_oe[0] && gp_pin_out[0] == $past(gp_pin_remote[0], 2))
      else $error("remote-hold pin lost its last value");

   a_default_on_loss: assert property (@(posedge clk) disable iff (srst) // see [R5]
      (m1 == gmc_pkg::M3_REMOTE_DEF) |=>
      gp_pin_oe[0] && gp_pin_out[0] == ($past(link_lock[0]) ? $past(gp_pin_remote[0]) :
      $past(v1)))
      else $error("remote-default pin value wrong");

   a_reg_only_modes: assert property (@(posedge clk) disable iff (srst) // see [R6]
      1'b1 |=> reg_only_oe[0] == ($past(m5) == gmc_pkg::M2_GPIO_OUT))
      else $error("register-only pin enable does not follow its mode");

   a_reg_only_value: assert property (@(posedge clk) disable iff (srst) // see [R7]
      (m5 == gmc_pkg::M2_GPIO_OUT) |=> reg_only_out[0] == $past(v5))
      else $error("register-only pin value wrong");

   a_pin12_write: assert property (@(posedge clk) disable iff (srst) // see [R8] [R11]
      s_wr_access(gmc_pkg::IDX_PIN12) ##0 (port_sel == 1'b0) |=>
      st_q.pin12[0] == $past(pwdata[7:0]) ##0 s_answer)
      else $error("pin1/pin2 write not stored");

   a_pin3_reserved: assert property (@(posedge clk) disable iff (srst) // see [R9]
      st_q.pin3[0][7:4] == 4'h0 && st_q.pin3[1][7:4] == 4'h0)
      else $error("pin3 reserved bits set");

   a_pair_reserved: assert property (@(posedge clk) disable iff (srst) // see [R10]
      s_wr_access(gmc_pkg::IDX_PIN56) |=> st_q.pin56 == ($past(pwdata[7:0]) & 8'hBB))
      else $error("pair register layout wrong");

   a_port_redirect: assert property (@(posedge clk) disable iff (srst) // see [R11]
      s_wr_access(gmc_pkg::IDX_PIN3) ##0 port_sel |=> $stable(st_q.pin3[0]))
      else $error("second-port write reached first port");

   a_reset_zero: assert property (@(posedge clk) // see [R12]
      $past(srst) |-> st_q.pin12 == '0 && st_q.pin3 == '0 && st_q.pin56 == 8'h00 &&
      st_q.pin78 == 8'h00 && !pready)
      else $error("configuration not zero after reset");

   a_lock_fallback: assert property (@(posedge clk) disable iff (srst) // see [R13]
      (m1 == gmc_pkg::M3_REMOTE_DEF) && link_lock[0] |=> gp_pin_out[0] == $past(gp_pin_remote[0]))
      else $error("locked remote pin not following remote value");
endmodule : gmc_bank

// File: core/gmc_pkg.sv
// shared constants and types for the pin mode configuration bank
package gmc_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_PIN12 = 8'h0E;
   localparam logic [7:0] IDX_PIN3 = 8'h0F;
   localparam logic [7:0] IDX_PIN56 = 8'h10;
   localparam logic [7:0] IDX_PIN78 = 8'h11;
   localparam logic [7:0] IDX_CTRL = 8'h20;
   localparam logic [7:0] IDX_STAT = 8'h21;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   // field positions
   localparam int UPPER_VAL_BIT = 7;
   localparam int UPPER_MODE_LSB = 4;
   localparam int LOWER_VAL_BIT = 3;
   localparam int LOWER_MODE_LSB = 0;
   localparam int CTRL_PORT_SEL_BIT = 0;
   localparam int STAT_LOCK0_BIT = 0;
   localparam int STAT_LOCK1_BIT = 1;
   localparam int STAT_IN_LSB = 2;
   // writable masks: reserved bits read as zero
   localparam logic [7:0] MASK_PIN12 = 8'hFF;
   localparam logic [7:0] MASK_PIN3 = 8'h0F;
   localparam logic [7:0] MASK_REG_ONLY = 8'hBB;
   localparam logic [7:0] MASK_CTRL = 8'h01;
   localparam logic [7:0] CFG_RESET = 8'h00;
   // three-bit mode codes; top bit ignored for functional and tri-state
   localparam logic [1:0] M3_FUNC_LOW = 2'h0;
   localparam logic [1:0] M3_TRI_LOW = 2'h2;
   localparam logic [2:0] M3_GPIO_OUT = 3'h1;
   localparam logic [2:0] M3_GPIO_IN = 3'h3;
   localparam logic [2:0] M3_REMOTE_HOLD = 3'h5;
   localparam logic [2:0] M3_REMOTE_DEF = 3'h7;
   // two-bit mode codes
   localparam logic [1:0] M2_FUNC = 2'h0;
   localparam logic [1:0] M2_GPIO_OUT = 2'h1;
   localparam logic [1:0] M2_TRI = 2'h2;
   localparam logic [1:0] M2_GPIO_IN = 2'h3;
   localparam int NUM_PORTS = 2;
   localparam int NUM_REMOTE = 3;
   localparam int NUM_REG_ONLY = 4;

   typedef struct packed {
      logic out;
      logic oe;
   } gmc_pin_drv_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_RESP = 2'b10
   } gmc_bus_st_t;
endpackage : gmc_pkg

// File: core/gmc_reg_pin.sv
// one register-only pin with a two-bit mode field
`timescale 1ns/1ps
module gmc_reg_pin (
   input wire logic clk,
   input wire logic srst,
   input wire logic [1:0] mode,
   input wire logic out_val,
   input wire logic pin_in,
   output gmc_pkg::gmc_pin_drv_t drv,
   output logic in_sample
);
   typedef struct packed {
      gmc_pkg::gmc_pin_drv_t drv;
      logic in_s;
   } gmc_gpin_st_t;

   gmc_gpin_st_t st_q;
   gmc_gpin_st_t st_d;

   always_comb begin
      st_d = st_q;
      st_d.drv.oe = 1'b0;
      st_d.drv.out = 1'b0;
      case (mode)
         gmc_pkg::M2_GPIO_OUT: begin
            st_d.drv.oe = 1'b1; // see [R6] [R7]
            st_d.drv.out = out_val;
         end
         gmc_pkg::M2_GPIO_IN: begin
            st_d.in_s = pin_in; // see [R6]
         end
         default: begin
            st_d.drv.oe = 1'b0; // see [R6]
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign drv = st_q.drv;
   assign in_sample = st_q.in_s;
endmodule : gmc_reg_pin

// File: core/gmc_remote_pin.sv
// one remotely capable pin with a three-bit mode field
`timescale 1ns/1ps
module gmc_remote_pin (
   input wire logic clk,
   input wire logic srst,
   input wire logic [2:0] mode,
   input wire logic out_val,
   input wire logic remote_val,
   input wire logic link_lock,
   input wire logic pin_in,
   output gmc_pkg::gmc_pin_drv_t drv,
   output logic in_sample
);
   typedef struct packed {
      gmc_pkg::gmc_pin_drv_t drv;
      logic hold;
      logic in_s;
   } gmc_rpin_st_t;

   gmc_rpin_st_t st_q;
   gmc_rpin_st_t st_d;

   always_comb begin
      st_d = st_q;
      st_d.drv.oe = 1'b0;
      st_d.drv.out = 1'b0;
      if (link_lock) begin
         st_d.hold = remote_val; // see [R4]
      end
      case (mode)
         gmc_pkg::M3_GPIO_OUT: begin
            st_d.drv.oe = 1'b1; // see [R1] [R3]
            st_d.drv.out = out_val;
         end
         gmc_pkg::M3_GPIO_IN: begin
            st_d.in_s = pin_in; // see [R3]
         end
         gmc_pkg::M3_REMOTE_HOLD: begin
            st_d.drv.oe = 1'b1;
            st_d.drv.out = link_lock ? remote_val : st_q.hold; // see [R4] [R13]
         end
         gmc_pkg::M3_REMOTE_DEF: begin
            st_d.drv.oe = 1'b1;
            st_d.drv.out = link_lock ? remote_val : out_val; // see [R5] [R13]
         end
         default: begin
            st_d.drv.oe = 1'b0; // see [R2]
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign drv = st_q.drv;
   assign in_sample = st_q.in_s;
endmodule : gmc_remote_pin

// File: test/gmc_bank_tb_top.sv
// self-checking bench for the pin mode configuration bank
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_total++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module gmc_bank_tb_top;
   typedef struct packed {
      logic [7:0] idx;
      logic [7:0] wd;
      logic [1:0] lock;
      logic [2:0] rem;
      logic [13:0] exp;
   } gmc_row_t;
   logic clk = 1'b0;
   logic srst, psel, penable, pwrite, pready, pslverr, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] lock_cmd, link_lock;
   logic [2:0] rem_cmd, gp_rem, sp_rem, gp_in, gp_out, gp_oe, sp_in, sp_out, sp_oe;
   logic [3:0] ro_in, ro_out, ro_oe;
   int err_total = 0;
   int checks = 0;
   gmc_row_t rows [20];
   always #2 clk = ~clk;
   gmc_bank gmc_bank_i (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link_lock(link_lock), .gp_pin_remote(gp_rem),
      .second_port_remote(sp_rem), .gp_pin_in(gp_in), .gp_pin_out(gp_out), .gp_pin_oe(gp_oe),
      .second_port_in(sp_in), .second_port_out(sp_out), .second_port_oe(sp_oe),
      .reg_only_in(ro_in), .reg_only_out(ro_out), .reg_only_oe(ro_oe));
   gmc_far_model gmc_far_model_i (.clk(clk), .lock_cmd(lock_cmd), .rem_cmd(rem_cmd),
      .link_lock(link_lock), .gp_pin_remote(gp_rem), .second_port_remote(sp_rem),
      .gp_pin_out(gp_out), .gp_pin_oe(gp_oe), .gp_pin_in(gp_in), .second_port_out(sp_out),
      .second_port_oe(sp_oe), .second_port_in(sp_in), .reg_only_out(ro_out),
      .reg_only_oe(ro_oe), .reg_only_in(ro_in));
   function automatic logic [11:0] ba(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction : ba
   function automatic logic [13:0] pv();
      return {gp_oe, gp_out & gp_oe, ro_oe, ro_out & ro_oe};
   endfunction : pv
   task automatic close_out();
      $display("errors=%0d checks=%0d", err_total, checks);
      if (err_total == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // value read right after the edge is the one that edge sampled
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         err_total++;
         close_out();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, ba(idx), {24'h000000, d});
   endtask : wreg
   task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
      apb(1'b0, ba(idx), 32'h00000000);
      `CHK(rd, {24'h000000, e})
   endtask : rchk
   task automatic settle();
      repeat (2) @(posedge clk);
      @(negedge clk);
   endtask : settle
   task automatic link(input logic [1:0] l, input logic [2:0] r);
      @(posedge clk);
      lock_cmd <= l;
      rem_cmd <= r;
      settle();
   endtask : link
   task automatic regs_zero();
      rchk(gmc_pkg::IDX_PIN12, 8'h00);
      rchk(gmc_pkg::IDX_PIN3, 8'h00);
      rchk(gmc_pkg::IDX_PIN56, 8'h00);
      rchk(gmc_pkg::IDX_PIN78, 8'h00);
      rchk(gmc_pkg::IDX_CTRL, 8'h00);
      `CHK({gp_oe, sp_oe, ro_oe}, 10'h000)
   endtask : regs_zero
   initial begin
      srst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      lock_cmd = 2'h0;
      rem_cmd = 3'h0;
      rows = '{
         '{gmc_pkg::IDX_PIN12, 8'h08, 2'h3, 3'h0, 14'h0000},
         '{gmc_pkg::IDX_PIN12, 8'h0C, 2'h3, 3'h0, 14'h0000},
         '{gmc_pkg::IDX_PIN12, 8'h0A, 2'h3, 3'h0, 14'h0000},
         '{gmc_pkg::IDX_PIN12, 8'h0E, 2'h3, 3'h0, 14'h0000},
         '{gmc_pkg::IDX_PIN12, 8'h09, 2'h3, 3'h0, 14'h0900},
         '{gmc_pkg::IDX_PIN12, 8'h01, 2'h3, 3'h0, 14'h0800},
         '{gmc_pkg::IDX_PIN12, 8'h0B, 2'h3, 3'h0, 14'h0000},
         '{gmc_pkg::IDX_PIN12, 8'h0D, 2'h3, 3'h0, 14'h0800},
         '{gmc_pkg::IDX_PIN12, 8'h0D, 2'h3, 3'h1, 14'h0900},
         '{gmc_pkg::IDX_PIN12, 8'h0D, 2'h0, 3'h0, 14'h0900},
         '{gmc_pkg::IDX_PIN12, 8'h0F, 2'h1, 3'h0, 14'h0800},
         '{gmc_pkg::IDX_PIN12, 8'h0F, 2'h2, 3'h0, 14'h0900},
         '{gmc_pkg::IDX_PIN12, 8'h07, 2'h0, 3'h7, 14'h0800},
         '{gmc_pkg::IDX_PIN12, 8'h90, 2'h0, 3'h0, 14'h1200},
         '{gmc_pkg::IDX_PIN3, 8'hF9, 2'h0, 3'h0, 14'h3600},
         '{gmc_pkg::IDX_PIN56, 8'h59, 2'h0, 3'h0, 14'h3631},
         '{gmc_pkg::IDX_PIN56, 8'h8E, 2'h0, 3'h0, 14'h3600},
         '{gmc_pkg::IDX_PIN56, 8'hBF, 2'h0, 3'h0, 14'h3600},
         '{gmc_pkg::IDX_PIN78, 8'h15, 2'h0, 3'h0, 14'h36C0},
         '{gmc_pkg::IDX_PIN78, 8'h99, 2'h0, 3'h0, 14'h36CC}
      };
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      regs_zero();
      foreach (rows[i]) begin
         link(rows[i].lock, rows[i].rem);
         wreg(rows[i].idx, rows[i].wd);
         settle();
         `CHK(pv(), rows[i].exp)
      end
      rchk(gmc_pkg::IDX_PIN3, 8'h09);
      rchk(gmc_pkg::IDX_PIN56, 8'hBB);
      rchk(gmc_pkg::IDX_PIN78, 8'h99);
      apb(1'b0, 12'h0C0, 32'h00000000);
      `CHK({er, rd}, 33'h100000000)
      apb(1'b1, ba(gmc_pkg::IDX_PIN12) | 12'h001, 32'h000000FF);
      `CHK(er, 1'b1)
      rchk(gmc_pkg::IDX_PIN12, 8'h90);
      wreg(gmc_pkg::IDX_CTRL, 8'h01);
      wreg(gmc_pkg::IDX_PIN12, 8'h99);
      settle();
      `CHK({sp_oe, sp_out & sp_oe}, 6'h1B)
      `CHK(pv(), 14'h36CC)
      rchk(gmc_pkg::IDX_PIN12, 8'h99);
      link(2'h2, 3'h7);
      wreg(gmc_pkg::IDX_PIN12, 8'h0F);
      settle();
      `CHK({sp_oe[0], sp_out[0]}, 2'b10)
      link(2'h1, 3'h7);
      `CHK({sp_oe[0], sp_out[0]}, 2'b11)
      wreg(gmc_pkg::IDX_CTRL, 8'h00);
      rchk(gmc_pkg::IDX_PIN12, 8'h90);
      @(posedge clk);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      regs_zero();
      rchk(gmc_pkg::IDX_STAT, 8'h01);
      close_out();
   end
endmodule : gmc_bank_tb_top

// File: test/gmc_far_model.sv
// far side model: link lock, remote pin values and pin loads
`timescale 1ns/1ps
module gmc_far_model (
   input wire logic clk,
   input wire logic [1:0] lock_cmd,
   input wire logic [2:0] rem_cmd,
   output logic [1:0] link_lock,
   output logic [2:0] gp_pin_remote,
   output logic [2:0] second_port_remote,
   input wire logic [2:0] gp_pin_out,
   input wire logic [2:0] gp_pin_oe,
   output logic [2:0] gp_pin_in,
   input wire logic [2:0] second_port_out,
   input wire logic [2:0] second_port_oe,
   output logic [2:0] second_port_in,
   input wire logic [3:0] reg_only_out,
   input wire logic [3:0] reg_only_oe,
   output logic [3:0] reg_only_in
);
   logic [9:0] last_q = 10'h000;
   logic [9:0] oe_all;
   logic [9:0] lvl;
   assign oe_all = {gp_pin_oe, second_port_oe, reg_only_oe};
   // undriven pins show a level that flips every cycle
   assign lvl = (oe_all & {gp_pin_out, second_port_out, reg_only_out}) | (~oe_all & ~last_q);
   always @(posedge clk) begin
      last_q <= lvl;
   end
   assign {gp_pin_in, second_port_in, reg_only_in} = lvl;
   assign link_lock = lock_cmd;
   assign gp_pin_remote = rem_cmd;
   assign second_port_remote = ~rem_cmd;
endmodule : gmc_far_model
